// ### hdl/alsm_limit_monitor.sv
/*
 * axis limit switch monitor: positive/negative limit and homing switch
 * evaluation, motor stop and jog-out release, fieldbus parameter access.
 * assumes inputs synchronous to clk and a word-wide parameter port.
 */
`timescale 1ns/10ps
`include "alsm_defines.svh"

module alsm_limit_monitor (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// switch inputs
	input  wire logic                 positive_limit_input,
	input  wire logic                 negative_limit_input,
	input  wire logic                 homing_switch_input,
	// motion state
	input  wire logic                 homing_active,
	input  wire logic                 jog_mode,
	input  wire logic                 move_dir_pos,
	input  wire logic                 move_req,
	// parameter access
	input  wire logic                 par_wr,
	input  wire logic                 par_rd,
	input  wire logic [15:0]          par_addr,
	input  wire alsm_pkg::alsm_word_t par_wdata,
	output alsm_pkg::alsm_word_t      par_rdata,
	output logic                      par_err,
	// results
	output logic                      motor_stop,
	output logic                      move_allow,
	output logic                      pos_limit_hit,
	output logic                      neg_limit_hit,
	output logic                      homing_switch_hit
);

	alsm_pkg::alsm_word_t  home_eval_q;
	alsm_pkg::alsm_word_t  neg_eval_q;
	alsm_pkg::alsm_word_t  pos_eval_q;
	alsm_pkg::alsm_word_t  rdata_d;
	alsm_pkg::alsm_state_e state_q;
	alsm_pkg::alsm_state_e state_d;
	logic                  err_d;
	logic                  limit_hit;
	logic                  jog_away;
	alsm_pkg::alsm_word_t  status_w;

	alsm_eval_if pos_ch ();
	alsm_eval_if neg_ch ();
	alsm_eval_if home_ch ();

	function automatic logic limit_code_ok(input alsm_pkg::alsm_word_t v);
		return v == `ALSM_EVAL_INACTIVE || v == `ALSM_EVAL_NC || v == `ALSM_EVAL_NO;
	endfunction

	function automatic logic home_code_ok(input alsm_pkg::alsm_word_t v);
		return v == `ALSM_EVAL_NC || v == `ALSM_EVAL_NO;
	endfunction

	// *****************************
	// parameter writes
	// *****************************
	always_ff @(posedge clk) begin
		if (rst)
			neg_eval_q <= `ALSM_EVAL_RESET;
		else if (par_wr && par_addr == `ALSM_ADDR_NEG_EVAL && limit_code_ok(par_wdata))
			neg_eval_q <= par_wdata;
	end

	always_ff @(posedge clk) begin
		if (rst)
			pos_eval_q <= `ALSM_EVAL_RESET;
		else if (par_wr && par_addr == `ALSM_ADDR_POS_EVAL && limit_code_ok(par_wdata))
			pos_eval_q <= par_wdata;
	end

	// homing setting never takes the inactive code
	always_ff @(posedge clk) begin
		if (rst)
			home_eval_q <= `ALSM_EVAL_RESET;
		else if (par_wr && par_addr == `ALSM_ADDR_HOMING_EVAL && home_code_ok(par_wdata))
			home_eval_q <= par_wdata;
	end

	// *****************************
	// parameter reads and error
	// *****************************
	always_comb begin
		rdata_d = 16'h0000;
		err_d   = 1'b0;
		unique case (par_addr)
			`ALSM_ADDR_HOMING_EVAL: begin
				rdata_d = home_eval_q;
				err_d   = par_wr && !home_code_ok(par_wdata);
			end
			`ALSM_ADDR_NEG_EVAL: begin
				rdata_d = neg_eval_q;
				err_d   = par_wr && !limit_code_ok(par_wdata);
			end
			`ALSM_ADDR_POS_EVAL: begin
				rdata_d = pos_eval_q;
				err_d   = par_wr && !limit_code_ok(par_wdata);
			end
			`ALSM_ADDR_STATUS: begin
				rdata_d = status_w;
				err_d   = par_wr;
			end
			default: err_d = par_wr || par_rd;
		endcase
		if (!(par_wr || par_rd))
			err_d = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (rst)
			par_rdata <= 16'h0000;
		else if (par_rd)
			par_rdata <= rdata_d;
	end

	always_ff @(posedge clk) begin
		if (rst)
			par_err <= 1'b0;
		else
			par_err <= err_d;
	end

	// *****************************
	// switch evaluation
	// *****************************
	assign pos_ch.setting  = pos_eval_q;
	assign pos_ch.raw      = positive_limit_input;
	assign neg_ch.setting  = neg_eval_q;
	assign neg_ch.raw      = negative_limit_input;
	assign home_ch.setting = home_eval_q;
	assign home_ch.raw     = homing_switch_input;

	// inactive setting yields no hit inside the evaluator
	alsm_switch_eval u_pos (
		.clk    (clk),
		.rst    (rst),
		.enable (1'b1),
		.ch     (pos_ch)
	);
	alsm_switch_eval u_neg (
		.clk    (clk),
		.rst    (rst),
		.enable (1'b1),
		.ch     (neg_ch)
	);
	alsm_switch_eval u_home (
		.clk    (clk),
		.rst    (rst),
		.enable (homing_active),
		.ch     (home_ch)
	);

	assign pos_limit_hit     = pos_ch.hit;
	assign neg_limit_hit     = neg_ch.hit;
	assign homing_switch_hit = home_ch.hit;

	// *****************************
	// status word
	// *****************************
	always_comb begin
		status_w                    = 16'h0000;
		status_w[`ALSM_ST_POS_HIT]  = pos_ch.hit;
		status_w[`ALSM_ST_NEG_HIT]  = neg_ch.hit;
		status_w[`ALSM_ST_HOME_HIT] = home_ch.hit;
		status_w[`ALSM_ST_STOP]     = motor_stop;
	end

	// *****************************
	// stop and jog-out release
	// *****************************
	assign limit_hit = pos_ch.hit || neg_ch.hit;
	// moving away means opposite direction of every active limit
	assign jog_away  = jog_mode && !(pos_ch.hit && move_dir_pos)
	                   && !(neg_ch.hit && !move_dir_pos);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			alsm_pkg::ALSM_RUN:
				if (limit_hit)
					state_d = alsm_pkg::ALSM_STOPPED;
			alsm_pkg::ALSM_STOPPED:
				if (!limit_hit)
					state_d = alsm_pkg::ALSM_RUN;
				else if (jog_away && move_req)
					state_d = alsm_pkg::ALSM_JOG_OUT;
			alsm_pkg::ALSM_JOG_OUT:
				if (!limit_hit)
					state_d = alsm_pkg::ALSM_RUN;
				else if (!jog_away)
					state_d = alsm_pkg::ALSM_STOPPED;
			default: state_d = alsm_pkg::ALSM_STOPPED;
		endcase
	end

	// *****************************
	// state register
	// *****************************
	always_ff @(posedge clk) begin
		if (rst)
			state_q <= alsm_pkg::ALSM_RUN;
		else
			state_q <= state_d;
	end

	// *****************************
	// outputs
	// *****************************
	// stop flag registered alongside the state
	always_ff @(posedge clk) begin
		if (rst)
			motor_stop <= 1'b0;
		else
			motor_stop <= (state_d == alsm_pkg::ALSM_STOPPED);
	end

	assign move_allow = move_req && (state_q == alsm_pkg::ALSM_RUN
	                    || (state_q == alsm_pkg::ALSM_JOG_OUT && jog_away));

endmodule // alsm_limit_monitor

// ### hdl/alsm_defines.svh
/*
 * limit switch monitor constants: parameter addresses, reset values, encodings.
 * assumes inclusion by bare name from the design files.
 */
`ifndef ALSM_DEFINES_SVH
`define ALSM_DEFINES_SVH

// *****************************
// parameter addresses
// *****************************
`define ALSM_ADDR_HOMING_EVAL   16'h061C
`define ALSM_ADDR_NEG_EVAL      16'h061E
`define ALSM_ADDR_POS_EVAL      16'h0620
`define ALSM_ADDR_STATUS        16'h0622

// *****************************
// reset values and encodings
// *****************************
`define ALSM_EVAL_RESET         16'h0001
`define ALSM_EVAL_INACTIVE      16'h0000
`define ALSM_EVAL_NC            16'h0001
`define ALSM_EVAL_NO            16'h0002

// *****************************
// status field positions
// *****************************
`define ALSM_ST_POS_HIT         0
`define ALSM_ST_NEG_HIT         1
`define ALSM_ST_HOME_HIT        2
`define ALSM_ST_STOP            3

`endif

// ### hdl/alsm_pkg.sv
/*
 * types shared by the limit switch monitor modules.
 * assumes the defines header is available.
 */
package alsm_pkg;

	typedef logic [15:0] alsm_word_t;

	// stop state machine, gray along run -> stopped -> jog out
	typedef enum logic [1:0] {
		ALSM_RUN     = 2'b00,
		ALSM_STOPPED = 2'b01,
		ALSM_JOG_OUT = 2'b11
	} alsm_state_e;

endpackage

// ### hdl/alsm_eval_if.sv
/*
 * interface carrying one switch evaluation: setting, raw input, result.
 * assumes a single clock domain.
 */
`timescale 1ns/10ps

interface alsm_eval_if;
	alsm_pkg::alsm_word_t setting;
	logic                 raw;
	logic                 hit;

	modport src (output setting, output raw, input hit);
	modport evl (input setting, input raw, output hit);
endinterface

// ### hdl/alsm_switch_eval.sv
/*
 * evaluates one switch input against its setting, registered result.
 * assumes the input is synchronous to clk.
 */
`timescale 1ns/10ps
`include "alsm_defines.svh"

module alsm_switch_eval (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// gating (homing only or always)
	input  wire logic enable,
	// evaluation channel
	alsm_eval_if.evl  ch
);

	logic hit_q;
	logic hit_d;

	// *****************************
	// contact polarity
	// *****************************
	always_comb begin
		hit_d = 1'b0;
		if (enable) begin
			if (ch.setting == `ALSM_EVAL_NC)
				hit_d = ~ch.raw;
			else if (ch.setting == `ALSM_EVAL_NO)
				hit_d = ch.raw;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			hit_q <= 1'b0;
		else
			hit_q <= hit_d;
	end

	assign ch.hit = hit_q;

endmodule // alsm_switch_eval

// ### verification/alsm_switch_model.sv
/* switch model: actuation to raw levels by contact wiring.
 * assumes bit0 positive, bit1 negative, bit2 homing. */
`timescale 1ns/10ps
module alsm_switch_model (
	// actuation and wiring
	input  wire logic [2:0] actuated,
	input  wire logic [2:0] wiring_no,
	// raw levels
	output logic      [2:0] level
);
	// closed contact opens when actuated
	assign level = actuated ^ ~wiring_no;
endmodule // alsm_switch_model

// ### verification/alsm_limit_monitor_monitor.sv
/* checker: stop, jog release, gating and parameter errors.
 * assumes binding to alsm_limit_monitor, one clock. */
`timescale 1ns/10ps
`include "alsm_defines.svh"
module alsm_limit_chk (
	// clock and reset
	input wire logic                 clk,
	input wire logic                 rst,
	// stimulus
	input wire logic                 homing_active,
	input wire logic                 jog_mode,
	input wire logic                 move_dir_pos,
	input wire logic                 move_req,
	input wire logic                 par_wr,
	input wire logic [15:0]          par_addr,
	input wire alsm_pkg::alsm_word_t par_wdata,
	// results
	input wire logic                 par_err,
	input wire logic                 motor_stop,
	input wire logic                 move_allow,
	input wire logic                 pos_limit_hit,
	input wire logic                 neg_limit_hit,
	input wire logic                 homing_switch_hit
);
	logic neg_off_q;
	always_ff @(posedge clk) begin
		if (rst)
			neg_off_q <= 1'b0;
		else if (par_wr && par_addr == `ALSM_ADDR_NEG_EVAL && par_wdata <= 16'h0002)
			neg_off_q <= (par_wdata == 16'h0000);
	end
	logic any_hit;
	assign any_hit = pos_limit_hit || neg_limit_hit;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence away_from_pos;
		motor_stop && jog_mode && move_req && !move_dir_pos && pos_limit_hit && !neg_limit_hit;
	endsequence
	sequence away_from_neg;
		motor_stop && jog_mode && move_req && move_dir_pos && neg_limit_hit && !pos_limit_hit;
	endsequence
	sequence bad_lim_wr;
		par_wr && (par_addr == `ALSM_ADDR_NEG_EVAL || par_addr == `ALSM_ADDR_POS_EVAL)
			&& par_wdata > 16'h0002;
	endsequence
	sequence bad_home_wr;
		par_wr && par_addr == `ALSM_ADDR_HOMING_EVAL
			&& (par_wdata == 16'h0000 || par_wdata > 16'h0002);
	endsequence
	pos_stop_a: assert property ($rose(pos_limit_hit) && !jog_mode |=> motor_stop)
		else $error("no stop after positive hit");
	neg_stop_a: assert property ($rose(neg_limit_hit) && !jog_mode |=> motor_stop)
		else $error("no stop after negative hit");
	stop_cause_a: assert property ($rose(motor_stop) |-> $past(any_hit))
		else $error("stop without hit");
	stop_blocks_a: assert property (motor_stop && !jog_mode |-> !move_allow)
		else $error("move allowed while stopped");
	jog_out_a: assert property (away_from_pos |=> !motor_stop)
		else $error("jog away not released");
	jog_neg_a: assert property (away_from_neg |=> !motor_stop)
		else $error("jog away from negative not released");
	neg_off_a: assert property (neg_off_q |=> !neg_limit_hit)
		else $error("inactive input hit");
	home_gate_a: assert property (!homing_active |=> !homing_switch_hit)
		else $error("homing hit outside homing");
	lim_code_a: assert property (bad_lim_wr |=> par_err)
		else $error("bad limit code accepted");
	home_code_a: assert property (bad_home_wr |=> par_err)
		else $error("bad homing code accepted");
endmodule // alsm_limit_chk
bind alsm_limit_monitor alsm_limit_chk chk_u (.clk, .rst, .homing_active, .jog_mode,
	.move_dir_pos, .move_req, .par_wr, .par_addr, .par_wdata, .par_err, .motor_stop,
	.move_allow, .pos_limit_hit, .neg_limit_hit, .homing_switch_hit);

// ### verification/alsm_limit_monitor_tb.sv
/* bench: parameter access and switch scenarios.
 * assumes the switch model drives the raw inputs. */
`timescale 1ns/10ps
`include "alsm_defines.svh"
module alsm_limit_monitor_tb;
	logic                 clk, rst, hom, jog, dir, req, wr, rd, err, stp, alw;
	logic [15:0]          adr;
	alsm_pkg::alsm_word_t wd, rdat;
	logic [2:0]           act, wno, lvl, hit;
	int                   bad_count, tests_run, cyc_cnt;
	alsm_switch_model sw_u (.actuated(act), .wiring_no(wno), .level(lvl));
	alsm_limit_monitor dut_u (.clk, .rst, .positive_limit_input(lvl[0]),
		.negative_limit_input(lvl[1]), .homing_switch_input(lvl[2]), .homing_active(hom),
		.jog_mode(jog), .move_dir_pos(dir), .move_req(req), .par_wr(wr), .par_rd(rd),
		.par_addr(adr), .par_wdata(wd), .par_rdata(rdat), .par_err(err), .motor_stop(stp),
		.move_allow(alw), .pos_limit_hit(hit[0]), .neg_limit_hit(hit[1]),
		.homing_switch_hit(hit[2]));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input string n, input logic [15:0] g, e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task chb(input string n, input logic g, e);
		chk(n, 16'(g), 16'(e));
	endtask
	task wr_p(input logic [15:0] a, d, input logic e);
		adr = a;
		wd = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		chb("par_err", err, e);
		cyc(1);
	endtask
	task rd_p(input logic [15:0] a, e);
		adr = a;
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		chk("par_rdata", rdat, e);
		cyc(1);
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 3000) begin
			bad_count++;
			print_verdict;
		end
	end
	initial begin
		{hom, jog, dir, req, wr, rd, adr, wd, act, wno} = '0;
		rst = 1'b1;
		cyc(8);
		rst = 1'b0;
		rd_p(`ALSM_ADDR_NEG_EVAL, 16'h0001);
		rd_p(`ALSM_ADDR_POS_EVAL, 16'h0001);
		rd_p(`ALSM_ADDR_HOMING_EVAL, 16'h0001);
		wr_p(`ALSM_ADDR_NEG_EVAL, 16'h0003, 1'b1);
		wr_p(`ALSM_ADDR_POS_EVAL, 16'hFFFF, 1'b1);
		wr_p(`ALSM_ADDR_HOMING_EVAL, 16'h0000, 1'b1);
		wr_p(`ALSM_ADDR_HOMING_EVAL, 16'h0003, 1'b1);
		wr_p(`ALSM_ADDR_HOMING_EVAL, 16'h0002, 1'b0);
		rd_p(`ALSM_ADDR_HOMING_EVAL, 16'h0002);
		rd_p(`ALSM_ADDR_NEG_EVAL, 16'h0001);
		wr_p(`ALSM_ADDR_STATUS, 16'h0000, 1'b1);
		for (int k = 0; k < 2; k++)
			for (int c = 2; c >= 0; c--) begin
				wr_p(k ? `ALSM_ADDR_POS_EVAL : `ALSM_ADDR_NEG_EVAL, 16'(c), 1'b0);
				rd_p(k ? `ALSM_ADDR_POS_EVAL : `ALSM_ADDR_NEG_EVAL, 16'(c));
			end
		$display("test codes done");
		wr_p(`ALSM_ADDR_POS_EVAL, 16'h0001, 1'b0);
		act[0] = 1'b1;
		cyc(1);
		chb("pos_limit_hit", hit[0], 1'b1);
		cyc(1);
		chb("motor_stop", stp, 1'b1);
		rd_p(`ALSM_ADDR_STATUS, 16'h0009);
		jog = 1'b1;
		dir = 1'b1;
		req = 1'b1;
		cyc(1);
		chb("move_allow", alw, 1'b0);
		chb("motor_stop", stp, 1'b1);
		dir = 1'b0;
		cyc(1);
		chb("motor_stop", stp, 1'b0);
		chb("move_allow", alw, 1'b1);
		{act, jog, req} = '0;
		cyc(3);
		$display("test positive stop done");
		wno[1] = 1'b1;
		wr_p(`ALSM_ADDR_NEG_EVAL, 16'h0002, 1'b0);
		chb("neg_limit_hit", hit[1], 1'b0);
		act[1] = 1'b1;
		cyc(2);
		chb("neg_limit_hit", hit[1], 1'b1);
		chb("motor_stop", stp, 1'b1);
		{jog, dir, req} = 3'h7;
		cyc(1);
		chb("motor_stop", stp, 1'b0);
		chb("move_allow", alw, 1'b1);
		{jog, req} = 2'h0;
		wr_p(`ALSM_ADDR_NEG_EVAL, 16'h0000, 1'b0);
		cyc(2);
		chb("neg_limit_hit", hit[1], 1'b0);
		chb("motor_stop", stp, 1'b0);
		$display("test negative done");
		{act, wno} = 6'h24;
		cyc(2);
		chb("homing_switch_hit", hit[2], 1'b0);
		hom = 1'b1;
		cyc(2);
		chb("homing_switch_hit", hit[2], 1'b1);
		$display("test homing done");
		print_verdict;
	end
endmodule // alsm_limit_monitor_tb
